// ### bench/sipol_assertions.sv
`timescale 1ns/1ps
module sipol_assertions #(parameter int WIDTH = 8) (
  // Pins
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic SERIAL_DATA_IN,
  input wire logic SHIFT_CLOCK,
  input wire logic SHIFT_CLEAR_N,
  input wire logic STORAGE_CLOCK,
  input wire logic STORAGE_CLEAR_N,
  // Outputs
  input wire logic [WIDTH-1:0] PARALLEL_OUT,
  input wire logic CASCADE_OUT
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  a_reset_out: assert property (
    $fell(SRST) |-> !CASCADE_OUT && PARALLEL_OUT == '0) else $error("reset");
  a_shift_clr: assert property (
    (!SHIFT_CLEAR_N)[*5] |-> !CASCADE_OUT) else $error("shift clear");
  a_store_clr: assert property (
    (!STORAGE_CLEAR_N)[*5] |-> PARALLEL_OUT == '0)
    else $error("store clear");
  a_shift_hold: assert property (
    (SHIFT_CLEAR_N && $stable(SHIFT_CLOCK))[*6] |-> $stable(CASCADE_OUT))
    else $error("cascade moved");
  a_store_hold: assert property (
    (STORAGE_CLEAR_N && $stable(STORAGE_CLOCK))[*6]
      |-> $stable(PARALLEL_OUT)) else $error("storage moved");
  a_store_indep: assert property (
    $fell(SHIFT_CLEAR_N) && !STORAGE_CLOCK |-> $stable(PARALLEL_OUT)[*5])
    else $error("storage hit");
  a_copy_last: assert property (
    $rose(STORAGE_CLOCK) && STORAGE_CLEAR_N && SHIFT_CLEAR_N && !SHIFT_CLOCK
      |-> ##6 PARALLEL_OUT[WIDTH-1] == CASCADE_OUT) else $error("copy");
  a_tied_lag: assert property (
    $rose(SHIFT_CLOCK && STORAGE_CLOCK) && SHIFT_CLEAR_N && STORAGE_CLEAR_N
      |-> ##6 PARALLEL_OUT[WIDTH-1] == $past(CASCADE_OUT, 6))
    else $error("lag");
  cover property ($rose(CASCADE_OUT));
  cover property ($fell(STORAGE_CLEAR_N));
  cover property ($rose(SHIFT_CLOCK && STORAGE_CLOCK));
endmodule : sipol_assertions

// ### bench/sipol_ctrl.sv
`timescale 1ns/1ps
module sipol_ctrl (
  // Pins
  output logic SERIAL_DATA_IN,
  output logic SHIFT_CLOCK,
  output logic STORAGE_CLOCK,
  output logic SHIFT_CLEAR_N,
  output logic STORAGE_CLEAR_N
);
  initial {SERIAL_DATA_IN, SHIFT_CLOCK, STORAGE_CLOCK,
           SHIFT_CLEAR_N, STORAGE_CLEAR_N} = 5'h03;
  // One 125 ns period, clears held over it
  task automatic pulse(input logic d, sh, st, s, r);
    {SERIAL_DATA_IN, SHIFT_CLEAR_N, STORAGE_CLEAR_N} = {d, s, r};
    #62.5 {SHIFT_CLOCK, STORAGE_CLOCK} = {sh, st};
    #62.5 {SHIFT_CLOCK, STORAGE_CLOCK, SHIFT_CLEAR_N, STORAGE_CLEAR_N} = 4'h3;
  endtask : pulse
endmodule : sipol_ctrl

// ### bench/sipol_top_tb.sv
`timescale 1ns/1ps
module sipol_top_tb;
  logic       SYS_CLK = 1'b0;
  logic       SRST = 1'b1;
  logic       SERIAL_DATA_IN, SHIFT_CLOCK, STORAGE_CLOCK, CASCADE_OUT;
  logic       SHIFT_CLEAR_N, STORAGE_CLEAR_N;
  logic [7:0] PARALLEL_OUT, exp_s, exp_r;
  int         num_errors = 0, checks_done = 0, cyc = 0;
  sipol_top  i_dut (.*);
  sipol_ctrl i_ctrl (.*);
  always #5 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) if (++cyc == 3000) begin
    num_errors++;
    conclude();
  end
  task automatic chk;
    logic [8:0] g = {CASCADE_OUT, PARALLEL_OUT}, w = {exp_s[7], exp_r};
    checks_done++;
    if (g !== w) begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, g, w);
    end
  endtask : chk
  task automatic step(input logic d, sh, st, s, r);
    i_ctrl.pulse(d, sh, st, s, r);
    if (!s) exp_s = 8'h00;
    if (st) exp_r = exp_s;
    if (sh && s) exp_s = {exp_s[6:0], d};
    if (!r) exp_r = 8'h00;
    repeat (2) @(posedge SYS_CLK);
    #1 chk();
  endtask : step
  task automatic t_load;
    logic [7:0] v = 8'hA7;
    for (int i = 7; i >= 0; i--) begin
      step(v[i], 1'b1, 1'b0, 1'b1, 1'b1);
    end
    step(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    $display("load done");
  endtask : t_load
  task automatic t_tied;
    for (int i = 0; i < 4; i++) begin
      step(i[0], 1'b1, 1'b1, 1'b1, 1'b1);
    end
    $display("tied done");
  endtask : t_tied
  task automatic t_clr;
    step(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    step(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    $display("clear done");
  endtask : t_clr
  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (3) @(posedge SYS_CLK);
    #1 SRST = 1'b0;
    {exp_s, exp_r} = 16'h0000;
    chk();
    t_load();
    t_tied();
    t_clr();
    conclude();
  end
endmodule : sipol_top_tb

bind sipol_top sipol_assertions #(.WIDTH(WIDTH)) i_chk (.*);

// ### core/sipol_edge.sv
`timescale 1ns/1ps
module sipol_edge
  import sipol_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // Synchronised levels
  input  wire logic         shift_clock,
  input  wire logic         storage_clock,
  // Rising edges
  output sipol_edges_t      edges
);

  typedef struct packed {
    logic shift_prev;
    logic storage_prev;
  } sipol_edge_t;

  sipol_edge_t state;
  sipol_edge_t next_state;

  always_comb begin
    next_state.shift_prev   = shift_clock;
    next_state.storage_prev = storage_clock;
    if (srst) begin
      next_state.shift_prev   = 1'b1;
      next_state.storage_prev = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
  end

  // Rising only; falling edges produce nothing
  assign edges.shift_rise   = shift_clock & ~state.shift_prev;
  assign edges.storage_rise = storage_clock & ~state.storage_prev;

endmodule : sipol_edge

// ### core/sipol_sync.sv
`timescale 1ns/1ps
module sipol_sync
  import sipol_pkg::*;
#(
  parameter int N = SIPOL_PINS
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // Pins
  input  wire logic [N-1:0] async_in,
  input  wire logic [N-1:0] reset_val,
  // Synchronised
  output logic      [N-1:0] sync_out
);

  typedef struct packed {
    logic [N-1:0] first;
    logic [N-1:0] second;
  } sipol_sync_t;

  sipol_sync_t state;
  sipol_sync_t next_state;

  always_comb begin
    next_state        = state;
    next_state.first  = async_in;
    next_state.second = state.first;
    if (srst) begin
      next_state.first  = reset_val;
      next_state.second = reset_val;
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
  end

  assign sync_out = state.second;

endmodule : sipol_sync

// ### core/sipol_top.sv
`timescale 1ns/1ps
module sipol_top
  import sipol_pkg::*;
#(
  parameter int WIDTH = SIPOL_WIDTH
) (
  // System
  input  wire logic             SYS_CLK,
  input  wire logic             SRST,
  // Serial side
  input  wire logic             SERIAL_DATA_IN,
  input  wire logic             SHIFT_CLOCK,
  input  wire logic             SHIFT_CLEAR_N,
  // Storage side
  input  wire logic             STORAGE_CLOCK,
  input  wire logic             STORAGE_CLEAR_N,
  // Outputs
  output logic      [WIDTH-1:0] PARALLEL_OUT,
  output logic                  CASCADE_OUT
);

  typedef struct packed {
    logic [WIDTH-1:0] shift;
    logic [WIDTH-1:0] storage;
    logic             cascade;
  } sipol_state_t;

  sipol_state_t state;
  sipol_state_t next_state;
  sipol_pins_t  pins_raw;
  sipol_pins_t  pins;
  sipol_pins_t  pins_idle;
  sipol_edges_t edges;

  always_comb begin
    pins_raw.shift_clock     = SHIFT_CLOCK;
    pins_raw.storage_clock   = STORAGE_CLOCK;
    pins_raw.serial_data_in  = SERIAL_DATA_IN;
    pins_raw.shift_clear_n   = SHIFT_CLEAR_N;
    pins_raw.storage_clear_n = STORAGE_CLEAR_N;
    pins_idle                = '0;
    pins_idle.shift_clear_n   = 1'b1;
    pins_idle.storage_clear_n = 1'b1;
    // Clocks idle high so a pin held high at release is no edge
    pins_idle.shift_clock     = 1'b1;
    pins_idle.storage_clock   = 1'b1;
  end

  // Two-stage pin synchronisers
  sipol_sync #(
    .N (SIPOL_PINS)
  ) u_sync (
    .clk       (SYS_CLK),
    .srst      (SRST),
    .async_in  (pins_raw),
    .reset_val (pins_idle),
    .sync_out  (pins)
  );

  // Clock edge finders
  sipol_edge u_edge (
    .clk           (SYS_CLK),
    .srst          (SRST),
    .shift_clock   (pins.shift_clock),
    .storage_clock (pins.storage_clock),
    .edges         (edges)
  );

  always_comb begin
    next_state = state;
    // Storage path: uses pre-edge shift contents
    if (!pins.storage_clear_n) begin
      next_state.storage = WIDTH'(SIPOL_CLEAR);
    end else if (edges.storage_rise) begin
      next_state.storage = state.shift;
    end
    // Shift path
    if (!pins.shift_clear_n) begin
      next_state.shift = WIDTH'(SIPOL_CLEAR);
    end else if (edges.shift_rise) begin
      next_state.shift = {state.shift[WIDTH-2:0],
                          pins.serial_data_in};
    end
    next_state.cascade = next_state.shift[WIDTH-1];
    if (SRST) begin
      next_state.shift   = WIDTH'(SIPOL_CLEAR);
      next_state.storage = WIDTH'(SIPOL_CLEAR);
      next_state.cascade = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    state <= next_state;
  end

  assign PARALLEL_OUT = state.storage;
  assign CASCADE_OUT  = state.cascade;

endmodule : sipol_top

// ### inc/sipol_pkg.sv
package sipol_pkg;

  localparam int SIPOL_WIDTH = 8;
  localparam int SIPOL_SYNC  = 2;

  localparam logic [SIPOL_WIDTH-1:0] SIPOL_CLEAR = 8'h00;

  // Synchronised pin levels
  typedef struct packed {
    logic shift_clock;
    logic storage_clock;
    logic serial_data_in;
    logic shift_clear_n;
    logic storage_clear_n;
  } sipol_pins_t;

  // Edge events for one system cycle
  typedef struct packed {
    logic shift_rise;
    logic storage_rise;
  } sipol_edges_t;

  localparam int SIPOL_PINS = $bits(sipol_pins_t);

endpackage : sipol_pkg
